// ---- rtl/ddm_top.sv ----
// Purpose: Two-channel downconverter mixer stage with loss-compensation
//          gain, oscillator control and I/Q output ordering.
// Assumes: Byte registers on a plain strobe port; samples arrive on the
//          same clock with valid/ready.
// Notes:   Output words go through an 8-deep FIFO; the source stalls
//          while the sequencer drains a sample.
`include "ddm_params.svh"
module ddm_top #(
  parameter int DEPTH = 8
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic [`DDM_FW-1:0]  osc_freq_word_b,
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire logic [`DDM_DW-1:0]  in_a,
  input  wire logic [`DDM_DW-1:0]  in_b,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output ddm_pkg::ddm_word_t       out_word
);
  localparam int DW = `DDM_DW;

  logic [7:0]          gain_q;
  logic [7:0]          ord_a_q;
  logic [7:0]          ord_b_q;
  logic [7:0]          dec_q;
  logic [`DDM_FW-1:0]  fw_a_q;
  logic [1:0]          rld_prev_q;
  logic                real_mode;
  logic [1:0]          gain_c [2];
  logic [1:0]          swap_v;
  logic [1:0]          qdel_v;
  logic [1:0]          qinv_v;
  logic [1:0]          qmix_v;
  logic [1:0]          rld_bit_v;
  logic [1:0]          rld_v;
  logic [1:0]          rot [2];
  logic [`DDM_FW-1:0]  phase [2];
  logic [`DDM_FW-1:0]  fw_sel [2];
  logic [DW-1:0]       samp [2];
  logic signed [DW:0]  ext_v [2];
  logic signed [DW:0]  neg_v [2];
  logic signed [DW:0]  mix_i [2];
  logic signed [DW:0]  mix_q [2];
  logic [DW-1:0]       hold_q [2];
  logic [DW-1:0]       i_q [2];
  logic [DW-1:0]       q_q [2];
  logic                accept;
  logic                ch;
  logic                first;
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  ddm_pkg::ddm_word_t  wr_word;
  ddm_pkg::ddm_state_t state_q;
  ddm_pkg::ddm_state_t state_d;

  // Field views of the control registers
  assign real_mode    = dec_q[`DDM_BIT_REAL];
  assign gain_c[0]    = gain_q[`DDM_GAIN_A_HI:`DDM_GAIN_A_LO];
  assign gain_c[1]    = gain_q[`DDM_GAIN_B_HI:`DDM_GAIN_B_LO];
  assign swap_v       = {ord_b_q[`DDM_BIT_SWAP], ord_a_q[`DDM_BIT_SWAP]};
  assign qdel_v       = {ord_b_q[`DDM_BIT_QDEL], ord_a_q[`DDM_BIT_QDEL]};
  assign qinv_v       = {ord_b_q[`DDM_BIT_QINV], ord_a_q[`DDM_BIT_QINV]};
  assign qmix_v       = {gain_q[`DDM_BIT_QMIX_B], gain_q[`DDM_BIT_QMIX_A]};
  assign rld_bit_v    = {gain_q[`DDM_BIT_RLD_B], gain_q[`DDM_BIT_RLD_A]};
  assign rld_v        = rld_bit_v ^ rld_prev_q;
  assign samp[0]      = in_a;
  assign samp[1]      = in_b;
  assign fw_sel[0]    = fw_a_q;
  assign fw_sel[1]    = osc_freq_word_b;

  // Loss-compensation gain with saturation; 3 dB is about x1.406
  function automatic logic [DW-1:0] apply_gain(
    input logic signed [DW:0] x,
    input logic        [1:0]  code
  );
    logic signed [DW+2:0] ext;
    logic signed [DW+2:0] w;
    ext = {{2{x[DW]}}, x};
    case (code)
      `DDM_GAIN_3DB: w = ext + (ext >>> 2) + (ext >>> 3) + (ext >>> 5);
      `DDM_GAIN_6DB: w = ext <<< 1;
      default:       w = ext; // Code 11 unused, treated as no gain
    endcase
    if (w[DW+2:DW-1] == '0 || w[DW+2:DW-1] == '1) begin
      apply_gain = w[DW-1:0];
    end else begin
      apply_gain = w[DW+2] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
    end
  endfunction

  // Control registers; reserved bits are not stored
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gain_q  <= `DDM_RST_REG;
      ord_a_q <= `DDM_RST_REG;
      ord_b_q <= `DDM_RST_REG;
      dec_q   <= `DDM_RST_REG;
    end else if (reg_wr) begin
      case (reg_addr)
        `DDM_OFS_GAIN:  gain_q  <= reg_wdata;
        `DDM_OFS_ORD_A: ord_a_q <= reg_wdata & `DDM_ORD_MASK;
        `DDM_OFS_ORD_B: ord_b_q <= reg_wdata & `DDM_ORD_MASK;
        `DDM_OFS_DEC:   dec_q   <= reg_wdata & `DDM_DEC_MASK;
        default: ;
      endcase
    end
  end

  // Frequency word A; real mode holds it at zero and drops writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fw_a_q <= '0;
    end else if (real_mode) begin
      fw_a_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `DDM_OFS_FW_A0: fw_a_q[7:0]   <= reg_wdata;
        `DDM_OFS_FW_A1: fw_a_q[15:8]  <= reg_wdata;
        `DDM_OFS_FW_A2: fw_a_q[23:16] <= reg_wdata;
        `DDM_OFS_FW_A3: fw_a_q[31:24] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Remember reload bits so any change of level gives one pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rld_prev_q <= 2'h0;
    end else begin
      rld_prev_q <= rld_bit_v;
    end
  end

  // Read data valid the cycle after the strobe; unmapped reads give 0
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `DDM_OFS_DEC:   reg_rdata <= dec_q;
        `DDM_OFS_GAIN:  reg_rdata <= gain_q;
        `DDM_OFS_ORD_A: reg_rdata <= ord_a_q;
        `DDM_OFS_FW_A0: reg_rdata <= fw_a_q[7:0];
        `DDM_OFS_FW_A1: reg_rdata <= fw_a_q[15:8];
        `DDM_OFS_FW_A2: reg_rdata <= fw_a_q[23:16];
        `DDM_OFS_FW_A3: reg_rdata <= fw_a_q[31:24];
        `DDM_OFS_ORD_B: reg_rdata <= ord_b_q;
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // One oscillator per channel; quarter-rate only in complex mode
  for (genvar g = 0; g < 2; g++) begin : g_osc
    ddm_osc u_osc (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .step      (accept),
      .reload    (rld_v[g]),
      .quarter   (qmix_v[g] && !real_mode),
      .invert    (qinv_v[g]),
      .freq_word (fw_sel[g]),
      .phase_q   (phase[g]),
      .rot       (rot[g])
    );
  end

  // Mixer: multiply by a quarter-turn rotation; real mode passes through
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ext_v[c] = {samp[c][DW-1], samp[c]};
      neg_v[c] = -ext_v[c];
      mix_i[c] = ext_v[c];
      mix_q[c] = '0;
      if (!real_mode) begin
        case (rot[c])
          2'h1: begin
            mix_i[c] = '0;
            mix_q[c] = neg_v[c];
          end
          2'h2: begin
            mix_i[c] = neg_v[c];
          end
          2'h3: begin
            mix_i[c] = '0;
            mix_q[c] = ext_v[c];
          end
          default: ;
        endcase
      end
    end
  end

  // Capture gained I/Q; Q-delay pairs the held I with the newer Q
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < 2; c++) begin
        hold_q[c] <= '0;
        i_q[c]    <= '0;
        q_q[c]    <= '0;
      end
    end else if (accept) begin
      for (int c = 0; c < 2; c++) begin
        hold_q[c] <= apply_gain(mix_i[c], gain_c[c]);
        q_q[c]    <= apply_gain(mix_q[c], gain_c[c]);
        if (qdel_v[c] && !real_mode) begin
          i_q[c] <= hold_q[c];
        end else begin
          i_q[c] <= apply_gain(mix_i[c], gain_c[c]);
        end
      end
    end
  end

  // Sequencer stalls the source until both channels are written out
  assign in_ready      = (state_q == ddm_pkg::ST_IDLE);
  assign accept        = in_valid && in_ready;
  assign fifo_in_valid = (state_q != ddm_pkg::ST_IDLE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ddm_pkg::ST_IDLE: begin
        if (accept) begin
          state_d = ddm_pkg::ST_A_FIRST;
        end
      end
      ddm_pkg::ST_A_FIRST: begin
        if (fifo_in_ready) begin
          state_d = real_mode ? ddm_pkg::ST_B_FIRST : ddm_pkg::ST_A_SECOND;
        end
      end
      ddm_pkg::ST_A_SECOND: begin
        if (fifo_in_ready) begin
          state_d = ddm_pkg::ST_B_FIRST;
        end
      end
      ddm_pkg::ST_B_FIRST: begin
        if (fifo_in_ready) begin
          state_d = real_mode ? ddm_pkg::ST_IDLE : ddm_pkg::ST_B_SECOND;
        end
      end
      ddm_pkg::ST_B_SECOND: begin
        if (fifo_in_ready) begin
          state_d = ddm_pkg::ST_IDLE;
        end
      end
      default: state_d = ddm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ddm_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Word order; real mode sends I only and ignores the swap bits
  always_comb begin
    ch    = (state_q == ddm_pkg::ST_B_FIRST) ||
            (state_q == ddm_pkg::ST_B_SECOND);
    first = (state_q == ddm_pkg::ST_A_FIRST) ||
            (state_q == ddm_pkg::ST_B_FIRST);
    wr_word.chan = ch;
    if (real_mode) begin
      wr_word.is_q = 1'b0;
    end else begin
      wr_word.is_q = first ? swap_v[ch] : !swap_v[ch];
    end
    wr_word.data = wr_word.is_q ? q_q[ch] : i_q[ch];
  end

  // Output FIFO; a slow sink backs up into in_ready
  ddm_fifo #(
    .WIDTH ($bits(ddm_pkg::ddm_word_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_word)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_fw_real_zero: assert property (real_mode |=> fw_a_q == '0)
    else $error("frequency word A not held at zero");
  a_reload_toggle_a: assert property (reg_wr &&
    reg_addr == `DDM_OFS_GAIN && reg_wdata[`DDM_BIT_RLD_A] != rld_bit_v[0]
    |=> rld_v[0])
    else $error("A reload change gave no pulse");
  // A back-to-back rewrite of the bit legally gives a second pulse
  a_reload_toggle_b: assert property (reg_wr &&
    reg_addr == `DDM_OFS_GAIN && reg_wdata[`DDM_BIT_RLD_B] != rld_bit_v[1]
    |=> rld_v[1] ##1 (!rld_v[1] ||
    $past(reg_wr && reg_addr == `DDM_OFS_GAIN)))
    else $error("B reload change gave no single pulse");
  a_gain_a_double: assert property (accept && !real_mode &&
    !qdel_v[0] && rot[0] == 2'h0 && gain_c[0] == `DDM_GAIN_6DB &&
    in_a[DW-1] == in_a[DW-2] |=> i_q[0] == {$past(in_a[DW-2:0]), 1'b0})
    else $error("A 6 dB gain wrong");
  a_gain_b_none: assert property (accept && real_mode &&
    (gain_c[1] == `DDM_GAIN_NONE || gain_c[1] == 2'h3) |=>
    i_q[1] == $past(in_b) && q_q[1] == '0)
    else $error("B unity gain or real path wrong");
  a_swap_order_a: assert property (state_q == ddm_pkg::ST_A_FIRST &&
    !real_mode |-> wr_word.is_q == swap_v[0] && !wr_word.chan)
    else $error("A first word order wrong");
  a_swap_order_b: assert property (state_q == ddm_pkg::ST_B_SECOND &&
    !real_mode |-> wr_word.is_q == !swap_v[1] && wr_word.chan)
    else $error("B second word order wrong");
  a_qdel_pair_a: assert property (accept && !real_mode && qdel_v[0] |=>
    i_q[0] == $past(hold_q[0]))
    else $error("A delayed pairing wrong");
  a_qdel_pair_b: assert property (accept && !real_mode &&
    qdel_v[1] |=> i_q[1] == $past(hold_q[1]))
    else $error("B Q delay did not hold I");
  a_real_seq: assert property (state_q == ddm_pkg::ST_A_FIRST &&
    real_mode && fifo_in_ready |=> state_q == ddm_pkg::ST_B_FIRST)
    else $error("real mode did not skip Q word");

  c_swap_complex: cover property (accept && !real_mode && swap_v[0]);
  c_qdel_both: cover property (accept && qdel_v == 2'h3 && !real_mode);
  c_reload_pulse: cover property (rld_v[0] ##1 accept);
  c_fifo_stall: cover property (fifo_in_valid && !fifo_in_ready);
endmodule

// ---- rtl/ddm_params.svh ----
// Purpose: Register offsets, field positions and reset values for the
//          downconverter mixer and I/Q order control.
// Assumes: Byte-wide registers on a plain address/strobe port.
// Notes:   Definitions only; included by bare name.
`ifndef DDM_PARAMS_SVH
`define DDM_PARAMS_SVH

// Sample and oscillator widths
`define DDM_DW          16
`define DDM_FW          32

// Register offsets
`define DDM_OFS_DEC     8'h25
`define DDM_OFS_GAIN    8'h26
`define DDM_OFS_ORD_A   8'h27
`define DDM_OFS_FW_A0   8'h2A
`define DDM_OFS_FW_A1   8'h2B
`define DDM_OFS_FW_A2   8'h2C
`define DDM_OFS_FW_A3   8'h2D
`define DDM_OFS_ORD_B   8'h2E

// Reset value of every control register
`define DDM_RST_REG     8'h00

// Decimation register field
`define DDM_BIT_REAL    3
`define DDM_DEC_MASK    8'h08

// Gain register fields
`define DDM_GAIN_A_HI   7
`define DDM_GAIN_A_LO   6
`define DDM_BIT_RLD_A   5
`define DDM_BIT_QMIX_A  4
`define DDM_GAIN_B_HI   3
`define DDM_GAIN_B_LO   2
`define DDM_BIT_RLD_B   1
`define DDM_BIT_QMIX_B  0

// Ordering register fields
`define DDM_BIT_SWAP    4
`define DDM_BIT_QDEL    3
`define DDM_BIT_QINV    2
`define DDM_ORD_MASK    8'h1C

// Gain codes
`define DDM_GAIN_NONE   2'h0
`define DDM_GAIN_3DB    2'h1
`define DDM_GAIN_6DB    2'h2

`endif

// ---- rtl/ddm_pkg.sv ----
// Purpose: Types shared by the downconverter mixer block and its bench.
// Assumes: ddm_params.svh supplies the sample width.
// Notes:   Nothing here is imported; users write ddm_pkg::name.
`include "ddm_params.svh"
package ddm_pkg;

  // One output word of the I/Q stream
  typedef struct packed {
    logic                chan;
    logic                is_q;
    logic [`DDM_DW-1:0]  data;
  } ddm_word_t;

  // Output sequencer states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_A_FIRST  = 3'b001,
    ST_A_SECOND = 3'b010,
    ST_B_FIRST  = 3'b011,
    ST_B_SECOND = 3'b100
  } ddm_state_t;

endpackage

// ---- rtl/ddm_fifo.sv ----
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: One clock; DEPTH is a power of two.
// Notes:   Full and empty come from pointers with one extra wrap bit.
module ddm_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = (wr_ptr_q != {~rd_ptr_q[AW], rd_ptr_q[AW-1:0]});
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

  // Storage has no reset; only pointers need a defined value
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule

// ---- rtl/ddm_osc.sv ----
// Purpose: Per-channel oscillator: phase accumulator and quarter-rate
//          rotation counter giving a two-bit mixer rotation index.
// Assumes: step is high once per accepted input sample.
// Notes:   Coarse mixer: the top two phase bits pick the rotation; in quarter mode the counter does.
`include "ddm_params.svh"
module ddm_osc (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              step,
  input  wire logic              reload,
  input  wire logic              quarter,
  input  wire logic              invert,
  input  wire logic [`DDM_FW-1:0] freq_word,
  output logic      [`DDM_FW-1:0] phase_q,
  output logic      [1:0]        rot
);
  logic [`DDM_FW-1:0] freq_q;
  logic [1:0]         qcnt_q;
  logic [1:0]         base;

  // Reload wins over step so the new word starts from phase zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= '0;
      freq_q  <= '0;
    end else if (reload) begin
      phase_q <= '0;
      freq_q  <= freq_word;
    end else if (step) begin
      phase_q <= phase_q + freq_q;
    end
  end

  // Quarter-rate counter walks 0,1,2,3 per sample
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      qcnt_q <= 2'h0;
    end else if (reload) begin
      qcnt_q <= 2'h0;
    end else if (step) begin
      qcnt_q <= qcnt_q + 2'h1;
    end
  end

  // Inversion runs the quarter-rate rotation backwards
  always_comb begin
    base = quarter ? qcnt_q : phase_q[`DDM_FW-1 -: 2];
    rot  = (quarter && invert) ? 2'(-base) : base;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_reload_phase_zero: assert property (reload |=> phase_q == '0 &&
    freq_q == $past(freq_word))
    else $error("reload did not clear phase or load word");
  a_accum_step: assert property (step && !reload |=>
    phase_q == $past(phase_q) + $past(freq_q))
    else $error("phase accumulator did not advance");
  a_quarter_fwd: assert property (quarter && !invert && step &&
    !reload ##1 quarter && !invert |-> rot == $past(rot) + 2'h1)
    else $error("quarter-rate rotation not forward");
  a_quarter_inv: assert property (quarter && invert && step &&
    !reload ##1 quarter && invert |-> rot == $past(rot) - 2'h1)
    else $error("inverted rotation not backward");
endmodule

// ---- verification/ddm_sink.sv ----
// Purpose: Host-side sink that takes the I/Q word stream.
// Assumes: hold stalls the stream; slow accepts every other cycle.
// Notes:   Taken words queue up in q for the bench to pop.
module ddm_sink (
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic               hold,
  input  wire logic               slow,
  input  wire logic               out_valid,
  output logic                    out_ready,
  input  wire ddm_pkg::ddm_word_t out_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] q[$];
  logic        tick;

  // Ready pattern; slow mode keeps the buffer half busy
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_ready <= 1'b0;
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      out_ready <= !hold && (!slow || tick);
    end
  end

  // Take a word on each edge with both sides high
  always @(posedge sys_clk) begin
    if (rst_b && out_valid && out_ready) q.push_back(out_word);
  end
endmodule

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the downconverter mixer stage.
// Assumes: Mixer with word 0 leaves I = x and Q = 0.
// Notes:   Each scenario resets first, so counters start from zero.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               sys_clk, rst_b, reg_wr, reg_rd, hold, slow;
  logic               in_valid, in_ready, out_valid, out_ready;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata;
  logic [15:0]        in_a, in_b;
  logic [31:0]        osc_freq_word_b;
  ddm_pkg::ddm_word_t out_word;
  int                 n_mismatch, n_tests;

  ddm_top u_ddm_top (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_freq_word_b(osc_freq_word_b),
    .in_valid(in_valid), .in_ready(in_ready), .in_a(in_a), .in_b(in_b),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
  ddm_sink u_ddm_sink (.sys_clk(sys_clk), .rst_b(rst_b), .hold(hold),
    .slow(slow), .out_valid(out_valid), .out_ready(out_ready),
    .out_word(out_word));

  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo();
    n_mismatch++;
    $display("Error at %0t: got %h expected %h", $time, 0, 1);
    final_report();
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    u_ddm_sink.q.delete();
  endtask

  // Register port: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // Released sample lines show the inverse, never the old value
  task automatic send(input logic [15:0] a, input logic [15:0] b);
    int i;
    @(posedge sys_clk);
    in_valid <= 1'b1;
    in_a <= a;
    in_b <= b;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (in_ready === 1'b1) break;
    end
    if (i == 50) tmo();
    in_valid <= 1'b0;
    in_a <= ~a;
    in_b <= ~b;
  endtask

  task automatic wait_words(input int n);
    int i;
    for (i = 0; i < 300 && u_ddm_sink.q.size() < n; i++) @(posedge sys_clk);
    if (i == 300) tmo();
  endtask

  function automatic logic [17:0] pop();
    return u_ddm_sink.q.pop_front();
  endfunction

  task automatic samp(input logic [15:0] a, b, input logic sa, sb,
                      input logic [15:0] ia, qa, ib, qb);
    send(a, b);
    wait_words(4);
    chk(pop(), sa ? {2'b01, qa} : {2'b00, ia});
    chk(pop(), sa ? {2'b00, ia} : {2'b01, qa});
    chk(pop(), sb ? {2'b11, qb} : {2'b10, ib});
    chk(pop(), sb ? {2'b10, ib} : {2'b11, qb});
  endtask

  // Quarter-turn rotation of a real sample, {I, Q}
  function automatic logic [31:0] rot(input logic [15:0] x, input int k);
    case (k & 3)
      0: return {x, 16'h0000};
      1: return {16'h0000, -x};
      2: return {-x, 16'h0000};
      default: return {16'h0000, x};
    endcase
  endfunction

  function automatic int kof(input logic [15:0] i, input logic [15:0] q);
    if (i === 16'h0100) return 0;
    if (q === 16'hFF00) return 1;
    if (i === 16'hFF00) return 2;
    return 3;
  endfunction

  task automatic getk(output int ka, output int kb);
    logic [17:0] w[4];
    send(16'h0100, 16'h0100);
    wait_words(4);
    foreach (w[j]) w[j] = pop();
    ka = kof(w[0][15:0], w[1][15:0]);
    kb = kof(w[2][15:0], w[3][15:0]);
  endtask

  task automatic t_regs();
    do_reset();
    rd(8'h26, 8'h00);
    rd(8'h27, 8'h00);
    rd(8'h2E, 8'h00);
    wr(8'h27, 8'hFF);
    rd(8'h27, 8'h1C);
    wr(8'h2E, 8'hFF);
    rd(8'h2E, 8'h1C);
    wr(8'h26, 8'hA5);
    rd(8'h26, 8'hA5);
    wr(8'h50, 8'h5A);
    rd(8'h50, 8'h00);
    for (logic [7:0] i = 0; i < 4; i++) begin
      wr(8'h2A + i, 8'h11 * (i + 8'h01));
    end
    for (logic [7:0] i = 0; i < 4; i++) begin
      rd(8'h2A + i, 8'h11 * (i + 8'h01));
    end
    wr(8'h25, 8'h08);
    rd(8'h25, 8'h08);
    rd(8'h2D, 8'h00);
    wr(8'h2A, 8'h77);
    rd(8'h2A, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_order();
    do_reset();
    wr(8'h27, 8'h18);
    wr(8'h2E, 8'h08);
    samp(16'h0111, 16'h0222, 1, 0, 16'h0000, 0, 16'h0000, 0);
    samp(16'h0333, 16'h0444, 1, 0, 16'h0111, 0, 16'h0222, 0);
    wr(8'h27, 8'h10);
    wr(8'h2E, 8'h00);
    samp(16'h0100, 16'h0200, 1, 0, 16'h0100, 0, 16'h0200, 0);
    wr(8'h27, 8'h00);
    wr(8'h2E, 8'h10);
    samp(16'h0100, 16'h0200, 0, 1, 16'h0100, 0, 16'h0200, 0);
    $display("t_order done");
  endtask

  task automatic t_quarter();
    logic [31:0] ra, rb;
    do_reset();
    wr(8'h26, 8'h11);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        wr(8'h27, 8'h04);
        wr(8'h2E, 8'h04);
      end
      ra = rot(16'h0100, k < 4 ? k : -k);
      rb = rot(16'h0200, k < 4 ? k : -k);
      samp(16'h0100, 16'h0200, 0, 0, ra[31:16], ra[15:0],
           rb[31:16], rb[15:0]);
    end
    $display("t_quarter done");
  endtask

  task automatic t_gain();
    logic [15:0] xs[5] = '{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h5000};
    logic [15:0] es[5] = '{16'h1000, 16'h1680, 16'h2000, 16'h1000, 16'h7FFF};
    logic [1:0]  cs[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
    do_reset();
    for (int i = 0; i < 5; i++) begin
      wr(8'h26, {cs[i], 2'b00, cs[i], 2'b00});
      samp(xs[i], xs[i], 0, 0, es[i], 0, es[i], 0);
    end
    $display("t_gain done");
  endtask

  task automatic t_osc();
    int a0, b0, a1, b1;
    do_reset();
    wr(8'h2D, 8'h40);
    osc_freq_word_b <= 32'hC000_0000;
    wr(8'h26, 8'h22);
    rd(8'h26, 8'h22);
    getk(a0, b0);
    getk(a1, b1);
    chk((a1 - a0) & 3, 1);
    chk((b1 - b0) & 3, 3);
    wr(8'h26, 8'h00);
    getk(a1, b1);
    chk(a1, a0);
    chk(b1, b0);
    $display("t_osc done");
  endtask

  task automatic t_real();
    do_reset();
    wr(8'h2D, 8'h40);
    wr(8'h25, 8'h08);
    wr(8'h26, 8'h31);
    send(16'h1234, 16'h5678);
    wait_words(2);
    repeat (10) @(posedge sys_clk);
    chk(u_ddm_sink.q.size(), 2);
    chk(pop(), {2'b00, 16'h1234});
    chk(pop(), {2'b10, 16'h5678});
    rd(8'h2D, 8'h00);
    $display("t_real done");
  endtask

  // Fill the buffer with the sink stalled, then drain it slowly
  task automatic t_fifo();
    do_reset();
    hold <= 1'b1;
    send(16'h0001, 16'h0002);
    send(16'h0003, 16'h0004);
    send(16'h0005, 16'h0006);
    repeat (10) @(posedge sys_clk);
    chk(in_ready, 0);
    chk(out_valid, 1);
    slow <= 1'b1;
    hold <= 1'b0;
    wait_words(12);
    repeat (3) @(posedge sys_clk);
    chk(u_ddm_sink.q.size(), 12);
    chk(pop(), {2'b00, 16'h0001});
    chk(out_valid, 0);
    chk(in_ready, 1);
    slow <= 1'b0;
    $display("t_fifo done");
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    {reg_wr, reg_rd, hold, slow, in_valid} = 5'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    {in_a, in_b} = 32'h0000_0000;
    osc_freq_word_b = 32'h0000_0000;
    n_mismatch = 0;
    n_tests = 0;
    t_regs();
    t_order();
    t_quarter();
    t_gain();
    t_osc();
    t_real();
    t_fifo();
    final_report();
  end
endmodule
